// >>> cbr_calib_route_regs.sv
// cbr_calib_route_regs: ahb-lite register bank for input routing and
// calibration control, with sequencing and routing decode below it.
// assumes: one ahb-lite master, single word transfers, zero wait states.
//
// How it works
// [R1] dual mode: swap bit 0 keeps A->A, B->B; 1 crosses the inputs.
// [R2] in single-channel lane formats the swap bit is ignored.
// [R3] single mode source: 1 input_a, 2 input_b, 3 split, 0 reserved.
// [R4] outside single-channel lane formats the source field is ignored.
// [R5] new routing is applied only when a calibration starts.
// [R6] run bit high runs calibration; low holds it in reset.
// [R7] clearing the run bit also resets the processing and link dividers.
// [R8] host clears run before calibration changes, then sets it to rerun.
// [R9] host sets run before link enable, drops link before run.
// [R10] background offset calibration needs background calibration too.
// [R11] foreground offset calibration needs foreground calibration too.
// [R12] each start resets calibration values; fg bit decides fg run.
// [R13] with background off, the idle core field picks the unused core.
// [R14] idle core selection is changed only while the link is disabled.
// [R15] averaging depths: offset at bits 6:4, linearity at bits 2:0.
// [R16] reserved bits store and return written values, reset to zero.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cbr_calib_route_regs
  import cbr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // ahb-lite slave
  input  wire logic              HSEL_I,
  input  wire logic [ADDR_W-1:0] HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic      [31:0]       HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  // device context, same clock
  input  wire logic              LANE_FMT_SINGLE_I,
  input  wire logic              SER_LINK_EN_I,
  // calibration engine
  output logic                   CAL_HOLD_O,
  output logic                   DIV_RST_O,
  output logic                   CAL_START_O,
  output logic                   FG_RUN_O,
  output logic                   FG_OS_EN_O,
  output logic                   BG_EN_O,
  output logic                   BG_OS_EN_O,
  output logic      [1:0]        IDLE_CORE_O,
  output logic                   IDLE_CORE_EN_O,
  output logic      [2:0]        OFFSET_AVG_DEPTH_O,
  output logic      [2:0]        LIN_AVG_O,
  // channel routing, 1 = samples input_b
  output logic                   CHA_SRC_B_O,
  output logic                   CHB_SRC_B_O
);

  // registers
  logic [REG_W-1:0] rt_q, rt_d;
  logic [REG_W-1:0] ce_q, ce_d;
  logic [REG_W-1:0] cp_q, cp_d;
  logic [REG_W-1:0] ic_q, ic_d;
  logic [REG_W-1:0] av_q, av_d;

  // bus pipeline
  logic             ap_take;
  logic             ap_ok;
  logic [7:0]       ap_idx;
  logic             dp_wr_q, dp_wr_d;
  logic [7:0]       dp_idx_q, dp_idx_d;
  logic [BUS_W-1:0] rdata_q, rdata_d;
  logic             ready_q;
  logic [REG_W-1:0] rd_sel;

  // address phase; upper address bits must be zero so no aliases appear
  assign ap_take = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign ap_ok   = (HADDR_I[ADDR_W-1:IDX_HI+1] == '0) & (HADDR_I[1:0] == 2'h0)
                   & (HSIZE_I <= HSIZE_WORD);
  assign ap_idx  = HADDR_I[IDX_HI:IDX_LO];

  // data phase capture
  always_comb begin
    dp_wr_d  = ap_take & HWRITE_I & ap_ok;
    dp_idx_d = ap_take ? ap_idx : dp_idx_q;
  end

  // register writes; all bits stored, reserved ones included
  always_comb begin
    rt_d = rt_q;
    ce_d = ce_q;
    cp_d = cp_q;
    ic_d = ic_q;
    av_d = av_q;
    if (dp_wr_q) begin
      case (dp_idx_q)
        IDX_INPUT_ROUTING:  rt_d = HWDATA_I[REG_W-1:0];    // R1 R3 R16
        IDX_CALIB_ENABLE:   ce_d = HWDATA_I[REG_W-1:0];    // R6 R16
        IDX_CALIB_PRIMARY:  cp_d = HWDATA_I[REG_W-1:0];    // R10 R11 R12 R16
        IDX_CALIB_IDLECORE: ic_d = HWDATA_I[REG_W-1:0];    // R13 R16
        IDX_CALIB_AVERAGE:  av_d = HWDATA_I[REG_W-1:0];    // R15 R16
        default: begin
          rt_d = rt_q;                                     // unmapped writes are dropped
        end
      endcase
    end
  end

  // read mux looks at next values so a read right after a write sees it
  always_comb begin
    case (ap_idx)
      IDX_INPUT_ROUTING:  rd_sel = rt_d;
      IDX_CALIB_ENABLE:   rd_sel = ce_d;
      IDX_CALIB_PRIMARY:  rd_sel = cp_d;
      IDX_CALIB_IDLECORE: rd_sel = ic_d;
      IDX_CALIB_AVERAGE:  rd_sel = av_d;
      default:            rd_sel = '0;
    endcase
    rdata_d = '0;
    if (ap_take & ~HWRITE_I & ap_ok) begin
      rdata_d = {{(BUS_W-REG_W){1'b0}}, rd_sel};           // R16
    end
  end

  // state registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rt_q     <= RST_INPUT_ROUTING;
      ce_q     <= RST_CALIB_ENABLE;
      cp_q     <= RST_CALIB_PRIMARY;
      ic_q     <= RST_CALIB_IDLECORE;
      av_q     <= RST_CALIB_AVERAGE;
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 8'h00;
      rdata_q  <= 32'h0000_0000;
      ready_q  <= 1'b0;
    end else begin
      rt_q     <= rt_d;
      ce_q     <= ce_d;
      cp_q     <= cp_d;
      ic_q     <= ic_d;
      av_q     <= av_d;
      dp_wr_q  <= dp_wr_d;
      dp_idx_q <= dp_idx_d;
      rdata_q  <= rdata_d;
      ready_q  <= 1'b1;                                    // never inserts wait states
    end
  end

  assign HRDATA_O    = rdata_q;
  assign HREADYOUT_O = ready_q;
  assign HRESP_O     = HRESP_OKAY;

  // averaging depths go straight from the stored fields
  assign OFFSET_AVG_DEPTH_O  = av_q[OFFSET_AVG_DEPTH_LSB +: 3];                // R15
  assign LIN_AVG_O = av_q[LIN_AVG_LSB +: 3];               // R15

  // fields to the controller and decoder
  cbr_cfg_if cfg ();

  assign cfg.routing     = rt_q;
  assign cfg.cal_enable  = ce_q;
  assign cfg.cal_primary = cp_q;
  assign cfg.idle_cfg    = ic_q;
  assign cfg.link_en     = SER_LINK_EN_I;                  // R9
  assign cfg.single_mode = LANE_FMT_SINGLE_I;              // R2 R4

  // calibration sequencing
  cbr_cal_ctrl u_ctrl (
    .clk_i          (CLK_I),
    .rst_n_i        (RST_N_I),
    .cfg            (cfg.ctl),
    .cal_hold_o     (CAL_HOLD_O),
    .div_rst_o      (DIV_RST_O),
    .cal_start_o    (CAL_START_O),
    .fg_run_o       (FG_RUN_O),
    .fg_os_en_o     (FG_OS_EN_O),
    .bg_en_o        (BG_EN_O),
    .bg_os_en_o     (BG_OS_EN_O),
    .idle_core_o    (IDLE_CORE_O),
    .idle_core_en_o (IDLE_CORE_EN_O)
  );

  // routing decode
  cbr_route u_route (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .cfg         (cfg.rte),
    .cha_src_b_o (CHA_SRC_B_O),
    .chb_src_b_o (CHB_SRC_B_O)
  );

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_run_fell;
    $fell(ce_q[CAL_RUN_BIT]);
  endsequence

  sequence s_start_pulse;
    CAL_START_O ##1 !CAL_START_O;
  endsequence

  property p_hold_on_clear;
    s_run_fell |=> CAL_HOLD_O;
  endproperty
  a_hold_on_clear: assert property (p_hold_on_clear) else $error("no hold after clear"); // R6

  property p_div_with_hold;
    DIV_RST_O == CAL_HOLD_O;
  endproperty
  a_div_with_hold: assert property (p_div_with_hold) else $error("divider reset mismatch"); // R7

  property p_start_on_set;
    $rose(ce_q[CAL_RUN_BIT]) |=> s_start_pulse;
  endproperty
  a_start_on_set: assert property (p_start_on_set) else $error("no start after set"); // R12

  property p_fg_run;
    CAL_START_O |-> FG_RUN_O == $past(cp_q[FG_CAL_BIT]);
  endproperty
  a_fg_run: assert property (p_fg_run) else $error("fg run mismatch"); // R12

  property p_fg_only_at_start;
    FG_RUN_O |-> CAL_START_O;
  endproperty
  a_fg_only_at_start: assert property (p_fg_only_at_start) else $error("fg run stray"); // R12

  property p_bg_offset;
    BG_OS_EN_O |-> BG_EN_O && $past(cp_q[BG_OS_BIT]);
  endproperty
  a_bg_offset: assert property (p_bg_offset) else $error("bg offset without bg"); // R10

  property p_fg_offset;
    FG_OS_EN_O |-> $past(cp_q[FG_CAL_BIT] && cp_q[FG_OS_BIT]);
  endproperty
  a_fg_offset: assert property (p_fg_offset) else $error("fg offset without fg"); // R11

  property p_idle_core;
    IDLE_CORE_EN_O |-> !$past(cp_q[BG_CAL_BIT]) && IDLE_CORE_O != IDLE_RSVD;
  endproperty
  a_idle_core: assert property (p_idle_core) else $error("idle core enable wrong"); // R13

  property p_write_read;
    dp_wr_q && dp_idx_q == IDX_INPUT_ROUTING |=> rt_q == $past(HWDATA_I[REG_W-1:0]);
  endproperty
  a_write_read: assert property (p_write_read) else $error("routing write lost"); // R16

  property p_read_data;
    ap_take && !HWRITE_I && ap_ok && ap_idx == IDX_CALIB_AVERAGE
      |=> HRDATA_O == {24'h000000, av_q};
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong"); // R15

  // stored fields checked against the written data, then enable and hold gating
  property p_offset_avg_depth_wr;
    dp_wr_q && dp_idx_q == IDX_CALIB_AVERAGE |=> OFFSET_AVG_DEPTH_O == $past(HWDATA_I[OFFSET_AVG_DEPTH_LSB +: 3]);
  endproperty
  a_offset_avg_depth_wr: assert property (p_offset_avg_depth_wr) else $error("offset depth lost"); // R15

  property p_lin_avg_wr;
    dp_wr_q && dp_idx_q == IDX_CALIB_AVERAGE |=> LIN_AVG_O == $past(HWDATA_I[LIN_AVG_LSB +: 3]);
  endproperty
  a_lin_avg_wr: assert property (p_lin_avg_wr) else $error("linearity depth lost"); // R15

  property p_primary_wr;
    dp_wr_q && dp_idx_q == IDX_CALIB_PRIMARY |=> cp_q == $past(HWDATA_I[REG_W-1:0]);
  endproperty
  a_primary_wr: assert property (p_primary_wr) else $error("primary write lost"); // R16

  property p_idle_wr;
    dp_wr_q && dp_idx_q == IDX_CALIB_IDLECORE |=> ic_q == $past(HWDATA_I[REG_W-1:0]);
  endproperty
  a_idle_wr: assert property (p_idle_wr) else $error("idle core write lost"); // R16

  property p_run_gates;
    !$past(ce_q[CAL_RUN_BIT]) |-> !BG_EN_O && !FG_OS_EN_O && !BG_OS_EN_O;
  endproperty
  a_run_gates: assert property (p_run_gates) else $error("enable while held"); // R6

  property p_hold_no_start;
    CAL_HOLD_O |-> !CAL_START_O && !FG_RUN_O;
  endproperty
  a_hold_no_start: assert property (p_hold_no_start) else $error("start while held"); // R6

  property p_idle_rsvd;
    IDLE_CORE_O == IDLE_RSVD |-> !IDLE_CORE_EN_O;
  endproperty
  a_idle_rsvd: assert property (p_idle_rsvd) else $error("reserved idle enabled"); // R13

  property p_start_leaves_hold;
    $rose(CAL_START_O) |-> $fell(CAL_HOLD_O);
  endproperty
  a_start_leaves_hold: assert property (p_start_leaves_hold) else $error("start in hold"); // R6 R12

  property p_div_on_clear;
    s_run_fell |=> DIV_RST_O;
  endproperty
  a_div_on_clear: assert property (p_div_on_clear) else $error("dividers run on clear"); // R7

  property p_fg_os_gate;
    !$past(cp_q[FG_CAL_BIT]) |-> !FG_OS_EN_O;
  endproperty
  a_fg_os_gate: assert property (p_fg_os_gate) else $error("fg offset without fg"); // R11

endmodule

// >>> cbr_pkg.sv
// cbr_pkg: register indices, field layout, reset values and encodings
// for the calibration and input routing register bank.
// assumes: registers sit in the low byte of aligned 32-bit words.
package cbr_pkg;

  // printed register offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_INPUT_ROUTING  = 8'h60;
  localparam logic [7:0] IDX_CALIB_ENABLE   = 8'h61;
  localparam logic [7:0] IDX_CALIB_PRIMARY  = 8'h62;
  localparam logic [7:0] IDX_CALIB_IDLECORE = 8'h64;
  localparam logic [7:0] IDX_CALIB_AVERAGE  = 8'h68;

  // reset values
  localparam logic [7:0] RST_INPUT_ROUTING  = 8'h01;
  localparam logic [7:0] RST_CALIB_ENABLE   = 8'h01;
  localparam logic [7:0] RST_CALIB_PRIMARY  = 8'h01;
  localparam logic [7:0] RST_CALIB_IDLECORE = 8'h02;
  localparam logic [7:0] RST_CALIB_AVERAGE  = 8'h61;

  // field positions
  localparam int DUAL_SWAP_BIT  = 4;
  localparam int SINGLE_SRC_LSB = 0;
  localparam int CAL_RUN_BIT    = 0;
  localparam int FG_CAL_BIT     = 0;
  localparam int BG_CAL_BIT     = 1;
  localparam int FG_OS_BIT      = 2;
  localparam int BG_OS_BIT      = 3;
  localparam int IDLE_CORE_LSB  = 0;
  localparam int OFFSET_AVG_DEPTH_LSB     = 4;
  localparam int LIN_AVG_LSB    = 0;
  localparam int REG_W          = 8;
  localparam int BUS_W          = 32;
  localparam int IDX_HI         = 9;
  localparam int IDX_LO         = 2;

  // single-channel source selection
  typedef enum logic [1:0] {
    SRC_RSVD  = 2'h0,
    SRC_A     = 2'h1,
    SRC_B     = 2'h2,
    SRC_SPLIT = 2'h3
  } cbr_src_t;

  localparam logic [1:0] IDLE_RSVD = 2'h3;

  // ahb-lite encodings
  localparam logic       HRESP_OKAY = 1'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // calibration control states, one-hot
  typedef enum logic [2:0] {
    ST_HOLD  = 3'h1,
    ST_START = 3'h2,
    ST_RUN   = 3'h4
  } cbr_state_t;

endpackage

// >>> cbr_cfg_if.sv
// cbr_cfg_if: carries register fields from the bank to the calibration
// controller and the routing decoder, and applied routing back out.
// assumes: all parties on one clock.
`timescale 1ns/1ps
interface cbr_cfg_if;
  logic [7:0] routing;
  logic [7:0] cal_enable;
  logic [7:0] cal_primary;
  logic [7:0] idle_cfg;
  logic       link_en;
  logic       single_mode;
  logic       app_swap;
  logic [1:0] app_src;

  modport regs (output routing, cal_enable, cal_primary, idle_cfg, link_en, single_mode);
  modport ctl  (input routing, cal_enable, cal_primary, idle_cfg, link_en,
                output app_swap, app_src);
  modport rte  (input app_swap, app_src, single_mode);
endinterface

// >>> cbr_route.sv
// cbr_route: decodes applied routing into per-channel input selection.
// assumes: applied routing fields change only at a calibration start.
`timescale 1ns/1ps
module cbr_route
  import cbr_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // configuration
  cbr_cfg_if.rte    cfg,
  // channel selection, 1 = samples input_b
  output logic      cha_src_b_o,
  output logic      chb_src_b_o
);

  logic cha_q;
  logic cha_d;
  logic chb_q;
  logic chb_d;

  // single mode uses only the source field, dual mode only the swap bit
  always_comb begin
    cha_d = 1'b0;
    chb_d = 1'b0;
    if (cfg.single_mode) begin
      case (cfg.app_src)
        SRC_A: begin                                       // R3
          cha_d = 1'b0;
          chb_d = 1'b0;
        end
        SRC_B: begin                                       // R3
          cha_d = 1'b1;
          chb_d = 1'b1;
        end
        SRC_SPLIT: begin                                   // R3
          cha_d = 1'b0;
          chb_d = 1'b1;
        end
        default: begin                                     // reserved code falls back to input_a
          cha_d = 1'b0;
          chb_d = 1'b0;
        end
      endcase
    end else begin
      cha_d = cfg.app_swap;                                // R1 R4
      chb_d = ~cfg.app_swap;                               // R1 R4
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cha_q <= 1'b0;
      chb_q <= 1'b0;
    end else begin
      cha_q <= cha_d;
      chb_q <= chb_d;
    end
  end

  assign cha_src_b_o = cha_q;
  assign chb_src_b_o = chb_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_dual_swap;
    $past(rst_n_i) && !$past(cfg.single_mode)
      |-> (cha_q == $past(cfg.app_swap)) && (chb_q != cha_q);
  endproperty
  a_dual_swap: assert property (p_dual_swap) else $error("dual routing wrong"); // R1 R4

  property p_single_src;
    $past(cfg.single_mode) && $past(cfg.app_src) == SRC_B |-> cha_q && chb_q;
  endproperty
  a_single_src: assert property (p_single_src) else $error("single routing wrong"); // R2 R3

endmodule

// >>> cbr_cal_ctrl.sv
// cbr_cal_ctrl: calibration hold/start sequencing and effective enables.
// assumes: register fields arrive on the same clock from the bank.
`timescale 1ns/1ps
module cbr_cal_ctrl
  import cbr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // configuration
  cbr_cfg_if.ctl          cfg,
  // calibration engine
  output logic            cal_hold_o,
  output logic            div_rst_o,
  output logic            cal_start_o,
  output logic            fg_run_o,
  output logic            fg_os_en_o,
  output logic            bg_en_o,
  output logic            bg_os_en_o,
  output logic [1:0]      idle_core_o,
  output logic            idle_core_en_o
);

  cbr_state_t state_q, state_d;
  logic       hold_q, hold_d, start_q, start_d, fgr_q, fgr_d;
  logic       fgos_q, fgos_d, bg_q, bg_d, bgos_q, bgos_d, ien_q, ien_d;
  logic       swap_q, swap_d;
  logic [1:0] src_q, src_d, idle_q, idle_d;
  logic       run;

  assign run = cfg.cal_enable[CAL_RUN_BIT];

  // next state and outputs; routing and fg run are taken at start, so routing
  // changes made while held take effect on the rerun
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:  state_d = run ? ST_START : ST_HOLD;        // R6
      ST_START: state_d = run ? ST_RUN : ST_HOLD;
      ST_RUN:   state_d = run ? ST_RUN : ST_HOLD;          // R6
      default:  state_d = ST_HOLD;
    endcase
    hold_d  = (state_d == ST_HOLD);                        // R6 R7
    start_d = (state_d == ST_START);                       // R12
    fgr_d   = start_d & cfg.cal_primary[FG_CAL_BIT];       // R12
    fgos_d  = run & cfg.cal_primary[FG_CAL_BIT] & cfg.cal_primary[FG_OS_BIT]; // R11
    bg_d    = run & cfg.cal_primary[BG_CAL_BIT];           // R10
    bgos_d  = run & cfg.cal_primary[BG_CAL_BIT] & cfg.cal_primary[BG_OS_BIT]; // R10
    // routing is applied only when a calibration starts
    swap_d  = (state_q == ST_START) ? cfg.routing[DUAL_SWAP_BIT] : swap_q; // R5
    src_d   = (state_q == ST_START) ? cfg.routing[SINGLE_SRC_LSB +: 2] : src_q; // R5
    // idle core follows the field only while the link is down
    idle_d  = cfg.link_en ? idle_q : cfg.idle_cfg[IDLE_CORE_LSB +: 2]; // R14
    ien_d   = ~cfg.cal_primary[BG_CAL_BIT] & (idle_d != IDLE_RSVD);    // R13
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_HOLD;
      hold_q  <= 1'b1;
      start_q <= 1'b0;
      fgr_q   <= 1'b0;
      fgos_q  <= 1'b0;
      bg_q    <= 1'b0;
      bgos_q  <= 1'b0;
      swap_q  <= RST_INPUT_ROUTING[DUAL_SWAP_BIT];
      src_q   <= RST_INPUT_ROUTING[SINGLE_SRC_LSB +: 2];
      idle_q  <= RST_CALIB_IDLECORE[IDLE_CORE_LSB +: 2];
      ien_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      start_q <= start_d;
      fgr_q   <= fgr_d;
      fgos_q  <= fgos_d;
      bg_q    <= bg_d;
      bgos_q  <= bgos_d;
      swap_q  <= swap_d;
      src_q   <= src_d;
      idle_q  <= idle_d;
      ien_q   <= ien_d;
    end
  end

  assign cal_hold_o     = hold_q;
  assign div_rst_o      = hold_q;                          // R7
  assign cal_start_o    = start_q;
  assign fg_run_o       = fgr_q;
  assign fg_os_en_o     = fgos_q;
  assign bg_en_o        = bg_q;
  assign bg_os_en_o     = bgos_q;
  assign idle_core_o    = idle_q;
  assign idle_core_en_o = ien_q;
  assign cfg.app_swap   = swap_q;
  assign cfg.app_src    = src_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_route_applied;
    $changed(swap_q) || $changed(src_q) |-> $past(state_q) == ST_START;
  endproperty
  a_route_applied: assert property (p_route_applied) else $error("routing moved without cal"); // R5

  property p_idle_link;
    $changed(idle_q) |-> !$past(cfg.link_en);
  endproperty
  a_idle_link: assert property (p_idle_link) else $error("idle core moved with link up"); // R14

endmodule

// >>> cbr_host_model.sv
// cbr_host_model: host that programs the bank over ahb-lite and owns
// the serial link enable level.
// assumes: hready_i is the slave's hreadyout; one clock for all.
`timescale 1ns/1ps
module cbr_host_model
  import cbr_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // ahb-lite master
  output logic             hsel_o,
  output logic [11:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // serial link
  output logic             link_en_o
);
  logic run_q;  // host copy of the run bit

  // bus idle until the first transfer
  initial begin
    run_q = 1'b1;
    hsel_o = 1'b0;
    haddr_o = 12'h000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = HSIZE_WORD;
    hwdata_o = 32'h0000_0000;
    link_en_o = 1'b0;
  end

  // single word transfer; no wait count assumed, only hready ends a phase
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {2'h0, i, 2'h0};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= w ? d : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~d;  // released data lines do not keep the last value
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    if (i == IDX_CALIB_ENABLE) run_q = d[0];
    xfer(1'b1, i, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    xfer(1'b0, i, 32'h0, q);
  endtask

  // link may only come up with calibration running
  task automatic link(input logic v);
    if (v && !run_q) run();
    @(posedge clk_i);
    link_en_o <= v;
  endtask

  // drop the link, then hold calibration before settings change
  task automatic hold();
    if (link_en_o === 1'b1) link(1'b0);
    wr(IDX_CALIB_ENABLE, 8'h00);
  endtask

  // rerun calibration so new settings take effect
  task automatic run();
    wr(IDX_CALIB_ENABLE, 8'h01);
  endtask
endmodule

// >>> cbr_calib_route_regs_tb_top.sv
// cbr_calib_route_regs_tb_top: self-checking bench for the register bank.
// assumes: cbr_host_model plays the host; lane format is driven here.
`timescale 1ns/1ps
module cbr_calib_route_regs_tb_top
  import cbr_pkg::*;
;
  // one routing case: lane format, routing, primary, expected outputs
  typedef struct packed {
    logic       sgl;
    logic [7:0] rte;
    logic [7:0] pri;
    logic [5:0] exp;
  } cbr_row_t;

  logic        clk, rst_n, lane, hsel, hwr, hrdy, hresp, link;
  logic [11:0] haddr;
  logic [1:0]  htrans, idle;
  logic [2:0]  hsize, osav, linav;
  logic [31:0] hwdata, hrdata;
  logic        hold, divr, start, fgrun, fgos, bg, bgos, idle_en, cha, chb;
  int          n_st, n_fg, error_cnt, comparisons;
  logic [7:0]  idx_a [5] = '{IDX_INPUT_ROUTING, IDX_CALIB_ENABLE, IDX_CALIB_PRIMARY,
                             IDX_CALIB_IDLECORE, IDX_CALIB_AVERAGE};
  logic [7:0]  rst_a [5] = '{RST_INPUT_ROUTING, RST_CALIB_ENABLE, RST_CALIB_PRIMARY,
                             RST_CALIB_IDLECORE, RST_CALIB_AVERAGE};
  // exp = {cha, chb, fg_os, bg, bg_os, idle_en}
  cbr_row_t    rows [10] = '{
    {1'b0, 8'h00, 8'h01, 6'h11}, {1'b0, 8'h10, 8'h05, 6'h29},
    {1'b0, 8'h13, 8'h04, 6'h21}, {1'b0, 8'h02, 8'h0A, 6'h16},
    {1'b1, 8'h01, 8'h08, 6'h01}, {1'b1, 8'h02, 8'h02, 6'h34},
    {1'b1, 8'h03, 8'h0F, 6'h1E}, {1'b1, 8'h11, 8'hF1, 6'h01},
    {1'b1, 8'h12, 8'h00, 6'h31}, {1'b1, 8'h00, 8'h01, 6'h01}};

  cbr_calib_route_regs i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwr), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .LANE_FMT_SINGLE_I(lane), .SER_LINK_EN_I(link), .CAL_HOLD_O(hold),
    .DIV_RST_O(divr), .CAL_START_O(start), .FG_RUN_O(fgrun), .FG_OS_EN_O(fgos),
    .BG_EN_O(bg), .BG_OS_EN_O(bgos), .IDLE_CORE_O(idle), .IDLE_CORE_EN_O(idle_en),
    .OFFSET_AVG_DEPTH_O(osav), .LIN_AVG_O(linav), .CHA_SRC_B_O(cha), .CHB_SRC_B_O(chb)
  );

  cbr_host_model i_host (
    .clk_i(clk), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwr),
    .hsize_o(hsize), .hwdata_o(hwdata), .hready_i(hrdy), .hrdata_i(hrdata),
    .link_en_o(link)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count start and fg pulses; a pulse stands one cycle only
  always @(posedge clk) begin
    n_st <= n_st + int'(start === 1'b1);
    n_fg <= n_fg + int'(fgrun === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // sample a settled value after n edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    int          s0, f0;
    logic [31:0] q;
    rst_n = 1'b0;
    lane = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk("starts", 32'h1, 32'(n_st));
    chk("fg runs", 32'h1, 32'(n_fg));
    chk("avg", {26'h0, RST_CALIB_AVERAGE[6:4], RST_CALIB_AVERAGE[2:0]}, {26'h0, osav, linav});
    $display("test reset done");
    foreach (idx_a[k]) begin
      i_host.rd(idx_a[k], q);
      chk("reset value", {24'h0, rst_a[k]}, q);
      i_host.wr(idx_a[k], ~rst_a[k]);
      i_host.rd(idx_a[k], q);
      chk("readback", {24'h0, ~rst_a[k]}, q);
    end
    chk("avg", {26'h0, ~RST_CALIB_AVERAGE[6:4], ~RST_CALIB_AVERAGE[2:0]}, {26'h0, osav, linav});
    i_host.wr(8'h63, 8'h5A);
    i_host.rd(8'h63, q);
    chk("unmapped", 32'h0, q);
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    foreach (idx_a[k]) i_host.wr(idx_a[k], rst_a[k]);
    $display("test registers done");
    // routing and enables, each case applied by a calibration rerun
    foreach (rows[k]) begin
      @(posedge clk);
      lane <= rows[k].sgl;
      s0 = n_st;
      f0 = n_fg;
      i_host.hold();
      i_host.wr(IDX_INPUT_ROUTING, rows[k].rte);
      i_host.wr(IDX_CALIB_PRIMARY, rows[k].pri);
      i_host.run();
      cyc(4);
      chk("route", {26'h0, rows[k].exp}, {26'h0, cha, chb, fgos, bg, bgos, idle_en});
      chk("starts", 32'(s0 + 1), 32'(n_st));
      chk("fg runs", 32'(f0) + 32'(rows[k].pri[0]), 32'(n_fg));
    end
    $display("test routing table done");
    // hold, then a routing change that must wait for the rerun
    @(posedge clk);
    lane <= 1'b0;
    i_host.wr(IDX_CALIB_ENABLE, 8'h00);
    cyc(1);
    chk("hold", 32'h3, {30'h0, hold, divr});
    i_host.wr(IDX_INPUT_ROUTING, 8'h10);
    cyc(4);
    chk("route held", 32'h1, {30'h0, cha, chb});
    i_host.run();
    cyc(1);
    chk("hold", 32'h0, {30'h0, hold, divr});
    cyc(3);
    chk("route new", 32'h2, {30'h0, cha, chb});
    $display("test hold done");
    // idle core frozen while the link runs, applied once it stops
    i_host.link(1'b1);
    i_host.wr(IDX_CALIB_IDLECORE, 8'h00);
    cyc(3);
    chk("idle frozen", {30'h0, RST_CALIB_IDLECORE[1:0]}, {30'h0, idle});
    i_host.link(1'b0);
    cyc(2);
    chk("idle core", 32'h0, {30'h0, idle});
    for (int c = 1; c < 4; c++) begin
      i_host.wr(IDX_CALIB_IDLECORE, 8'(c));
      cyc(2);
      chk("idle en", 32'(c != 3), {31'h0, idle_en});
      if (c != 3) chk("idle core", 32'(c), {30'h0, idle});
    end
    $display("test idle core done");
    // reset in mid-run restores the bank
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk("in reset", 32'h2, {30'h0, hold, hrdy});
    @(posedge clk);
    rst_n <= 1'b1;
    i_host.rd(IDX_CALIB_IDLECORE, q);
    chk("reset value", {24'h0, RST_CALIB_IDLECORE}, q);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
